// [rtl/exec_slice.sv]
// Purpose: Executes rotate, subtract and sleep instructions written over AXI4-Lite.
// Assumes: One write and one read at most under way; same clock as the bus master.
// Notes: Writing the instruction register in run mode runs it in the same cycle as the write completes.
// Summary of operation
// RULE1 - Rotate right moves old carry into bit 7, bit 0 into carry only.
// RULE2 - Rotate result goes to accumulator on select 0, file register on 1.
// RULE3 - Literal minus accumulator into accumulator; carry and half-carry mean no borrow.
// RULE4 - Register minus accumulator sets carry, half-carry and zero likewise.
// RULE5 - Register minus accumulator result goes to accumulator on 0, else file.
// RULE6 - Borrow form also subtracts inverted carry; flags and destination as above.
// RULE7 - Sleep clears the powerdown flag and sets the timeout flag.
// RULE8 - Sleep clears the watchdog counter and its prescaler.
// RULE9 - After sleep execution halts with the oscillator stopped.
// RULE10 - Every subtraction sets zero when the 8-bit result is zero.
`timescale 1ns/1ps
`default_nettype none
module exec_slice #(
  parameter int PRE_W = exec_pkg::PRE_W_DEF
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [exec_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [exec_pkg::DATA_W-1:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [exec_pkg::ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [exec_pkg::DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic sleeping_o
);
  import exec_pkg::*;

  typedef struct packed {
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [7:0] acc;
    logic c;
    logic dc;
    logic z;
    logic pd;
    logic to;
    run_e mode;
    logic [FADDR_W-1:0] fsel;
    logic [7:0] wdog;
    logic [PRE_W-1:0] pre;
    logic [FILE_DEPTH-1:0][7:0] mem;
  } state_s;

  state_s st_reg;
  state_s st_next;
  alu_if alu_bus();

  logic wr_fire;
  logic [DATA_W-1:0] wr_word;
  logic exec_fire;
  op_e ex_op;
  logic ex_dest;
  logic [FADDR_W-1:0] ex_faddr;
  logic [7:0] ex_lit;
  logic [7:0] ex_fval;

  // A write completes once address and data are both held and no answer is pending.
  assign wr_fire = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
  assign wr_word = merge_strb('0, st_reg.w_data, st_reg.w_strb);
  assign exec_fire = wr_fire && (st_reg.aw_addr == OFS_INSTR) && (st_reg.mode == RUN_MODE);

  // Decodes the instruction word and feeds the arithmetic unit.
  assign ex_op = op_e'(wr_word[INSTR_OP_LSB +: 3]);
  assign ex_dest = wr_word[INSTR_DEST_BIT];
  assign ex_faddr = wr_word[INSTR_FADDR_LSB +: FADDR_W];
  assign ex_lit = wr_word[INSTR_LIT_LSB +: 8];
  assign ex_fval = st_reg.mem[ex_faddr];
  assign alu_bus.op = exec_fire ? ex_op : OP_NONE;
  assign alu_bus.acc = st_reg.acc;
  assign alu_bus.fval = ex_fval;
  assign alu_bus.lit = ex_lit;
  assign alu_bus.carry_in = st_reg.c;

  sub_rot_alu u_alu (
    .bus(alu_bus.unit)
  );

  // Bus handshakes are combinational; data and answers come from the state.
  assign awready_o = !st_reg.aw_full;
  assign wready_o = !st_reg.w_full;
  assign arready_o = !st_reg.rvalid;
  assign bvalid_o = st_reg.bvalid;
  assign bresp_o = st_reg.bresp;
  assign rvalid_o = st_reg.rvalid;
  assign rdata_o = st_reg.rdata;
  assign rresp_o = st_reg.rresp;
  assign sleeping_o = (st_reg.mode == SLEEP_MODE);

  // Next-state logic: bus slave, register writes, execution and watchdog.
  always_comb begin
    st_next = st_reg;
    // Channel capture and answer release.
    if (awvalid_i && !st_reg.aw_full) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = awaddr_i;
    end
    if (wvalid_i && !st_reg.w_full) begin
      st_next.w_full = 1'b1;
      st_next.w_data = wdata_i;
      st_next.w_strb = wstrb_i;
    end
    if (st_reg.bvalid && bready_i) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && rready_i) begin
      st_next.rvalid = 1'b0;
    end
    // The watchdog only advances while the oscillator runs.
    unique case (st_reg.mode)
      RUN_MODE: begin
        st_next.pre = st_reg.pre + PRE_W'(1);
        if (&st_reg.pre) begin
          st_next.wdog = st_reg.wdog + 8'h01;
          if (&st_reg.wdog) begin
            st_next.to = 1'b0;
          end
        end
      end
      SLEEP_MODE: begin
        st_next.pre = st_reg.pre; // see RULE9
      end
    endcase
    // Register reads answer in the cycle after the address is taken.
    if (arvalid_i && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = '0;
      case (araddr_i)
        OFS_INSTR, OFS_WAKE: st_next.rdata = '0;
        OFS_ACC: st_next.rdata[7:0] = st_reg.acc;
        OFS_STATUS: begin
          st_next.rdata[ST_C_BIT] = st_reg.c;
          st_next.rdata[ST_DC_BIT] = st_reg.dc;
          st_next.rdata[ST_Z_BIT] = st_reg.z;
          st_next.rdata[ST_PD_BIT] = st_reg.pd;
          st_next.rdata[ST_TO_BIT] = st_reg.to;
          st_next.rdata[ST_SLEEP_BIT] = (st_reg.mode == SLEEP_MODE);
        end
        OFS_WDOG: begin
          st_next.rdata[WDOG_CNT_LSB +: 8] = st_reg.wdog;
          st_next.rdata[WDOG_PRE_LSB +: PRE_W] = st_reg.pre;
        end
        OFS_FSEL: st_next.rdata[FADDR_W-1:0] = st_reg.fsel;
        OFS_FDATA: st_next.rdata[7:0] = st_reg.mem[st_reg.fsel];
        default: st_next.rresp = RESP_SLVERR;
      endcase
    end
    // Register writes; an instruction written while asleep is ignored.
    if (wr_fire) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case (st_reg.aw_addr)
        OFS_INSTR: st_next.bresp = RESP_OKAY;
        OFS_ACC: begin
          if (st_reg.w_strb[0]) begin
            st_next.acc = st_reg.w_data[7:0];
          end
        end
        OFS_STATUS: begin
          if (st_reg.w_strb[0]) begin
            st_next.c = st_reg.w_data[ST_C_BIT];
            st_next.dc = st_reg.w_data[ST_DC_BIT];
            st_next.z = st_reg.w_data[ST_Z_BIT];
          end
        end
        OFS_FSEL: begin
          if (st_reg.w_strb[0]) begin
            st_next.fsel = st_reg.w_data[FADDR_W-1:0];
          end
        end
        OFS_FDATA: begin
          if (st_reg.w_strb[0]) begin
            st_next.mem[st_reg.fsel] = st_reg.w_data[7:0];
          end
        end
        OFS_WAKE: begin
          if (st_reg.w_strb[0] && st_reg.w_data[WAKE_BIT]) begin
            st_next.mode = RUN_MODE;
          end
        end
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    // Execution of the instruction just written.
    if (exec_fire) begin
      if (alu_bus.carry_we) begin
        st_next.c = alu_bus.carry_out; // see RULE1
      end
      if (alu_bus.arith_we) begin
        st_next.dc = alu_bus.half_carry_out; // see RULE3 see RULE4 see RULE6
        st_next.z = alu_bus.zero_out; // see RULE10
      end
      if (ex_op == OP_LITERAL_MINUS_ACC) begin
        st_next.acc = alu_bus.result; // see RULE3
      end else if (ex_op == OP_ROTATE_RIGHT_CARRY || ex_op == OP_REG_MINUS_ACC ||
                   ex_op == OP_REG_MINUS_ACC_BORROW) begin
        if (ex_dest) begin
          st_next.mem[ex_faddr] = alu_bus.result; // see RULE2 see RULE5 see RULE6
        end else begin
          st_next.acc = alu_bus.result; // see RULE2 see RULE5 see RULE6
        end
      end else if (ex_op == OP_SLEEP) begin
        st_next.pd = 1'b0; // see RULE7
        st_next.to = 1'b1; // see RULE7
        st_next.wdog = 8'h00; // see RULE8
        st_next.pre = '0; // see RULE8
        st_next.mode = SLEEP_MODE; // see RULE9
      end
    end
  end

  // State register with synchronous active-low reset.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.acc <= ACC_RST;
      st_reg.pd <= PD_RST;
      st_reg.to <= TO_RST;
      st_reg.mode <= RUN_MODE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Checks of the documented behaviour.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_rrf_carry;
    exec_fire && ex_op == OP_ROTATE_RIGHT_CARRY |=>
      st_reg.c == $past(ex_fval[0]) && $stable(st_reg.dc) && $stable(st_reg.z);
  endproperty
  a_rrf_carry: assert property (p_rrf_carry) else $error("rotate carry wrong"); // see RULE1

  property p_rrf_dest;
    exec_fire && ex_op == OP_ROTATE_RIGHT_CARRY && !ex_dest |=>
      st_reg.acc == {$past(st_reg.c), $past(ex_fval[7:1])};
  endproperty
  a_rrf_dest: assert property (p_rrf_dest) else $error("rotate result wrong"); // see RULE2

  property p_literal_minus_acc;
    exec_fire && ex_op == OP_LITERAL_MINUS_ACC |=>
      st_reg.acc == 8'($past(ex_lit) - $past(st_reg.acc)) &&
      st_reg.c == ($past(st_reg.acc) <= $past(ex_lit)) &&
      st_reg.dc == ($past(st_reg.acc[3:0]) <= $past(ex_lit[3:0]));
  endproperty
  a_literal_minus_acc: assert property (p_literal_minus_acc) else $error("literal subtract wrong"); // see RULE3

  property p_reg_minus_acc_flags;
    exec_fire && ex_op == OP_REG_MINUS_ACC |=>
      st_reg.c == ($past(st_reg.acc) <= $past(ex_fval)) &&
      st_reg.dc == ($past(st_reg.acc[3:0]) <= $past(ex_fval[3:0]));
  endproperty
  a_reg_minus_acc_flags: assert property (p_reg_minus_acc_flags) else $error("subtract flags wrong"); // see RULE4

  property p_reg_minus_acc_dest;
    exec_fire && ex_op == OP_REG_MINUS_ACC && ex_dest |=>
      st_reg.mem[$past(ex_faddr)] == 8'($past(ex_fval) - $past(st_reg.acc)) &&
      $stable(st_reg.acc);
  endproperty
  a_reg_minus_acc_dest: assert property (p_reg_minus_acc_dest) else $error("subtract dest wrong"); // see RULE5

  property p_reg_minus_acc_borrow;
    exec_fire && ex_op == OP_REG_MINUS_ACC_BORROW && !ex_dest |=>
      st_reg.acc == 8'($past(ex_fval) - $past(st_reg.acc) - {7'h00, !$past(st_reg.c)});
  endproperty
  a_reg_minus_acc_borrow: assert property (p_reg_minus_acc_borrow) else $error("borrow subtract wrong"); // see RULE6

  property p_sleep_flags;
    exec_fire && ex_op == OP_SLEEP |=> !st_reg.pd && st_reg.to;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong"); // see RULE7

  property p_sleep_wdog;
    exec_fire && ex_op == OP_SLEEP |=> st_reg.wdog == 8'h00 && st_reg.pre == '0;
  endproperty
  a_sleep_wdog: assert property (p_sleep_wdog) else $error("watchdog not cleared"); // see RULE8

  property p_sleep_halt;
    exec_fire && ex_op == OP_SLEEP ##1 (sleeping_o && !wr_fire)[*3] |->
      $stable(st_reg.wdog) && $stable(st_reg.pre) && $stable(st_reg.acc);
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("core ran while asleep"); // see RULE9

  property p_zero;
    exec_fire && alu_bus.arith_we |=> st_reg.z == ($past(alu_bus.result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // see RULE10

  // Main scenarios.
  c_rotate: cover property (exec_fire && ex_op == OP_ROTATE_RIGHT_CARRY && ex_dest);
  c_borrow: cover property (exec_fire && ex_op == OP_REG_MINUS_ACC_BORROW && !st_reg.c);
  c_lit_zero: cover property (exec_fire && ex_op == OP_LITERAL_MINUS_ACC && alu_bus.zero_out);
  c_sleep_wake: cover property (sleeping_o ##[1:20] !sleeping_o);

endmodule : exec_slice
`default_nettype wire

// [rtl/exec_pkg.sv]
// Purpose: Shared constants and types for the subtract, rotate and sleep execution slice.
// Assumes: AXI4-Lite register access with 32-bit data and byte addresses.
// Notes: Register offsets are byte addresses of aligned words.
package exec_pkg;

  // Register bus widths and answers.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register offsets.
  localparam logic [ADDR_W-1:0] OFS_INSTR = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ACC = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_WDOG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FSEL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FDATA = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_WAKE = 8'h18;

  // Instruction word fields.
  localparam int INSTR_OP_LSB = 0;
  localparam int INSTR_DEST_BIT = 7;
  localparam int INSTR_FADDR_LSB = 8;
  localparam int INSTR_LIT_LSB = 16;

  // Status word bit positions.
  localparam int ST_C_BIT = 0;
  localparam int ST_DC_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_PD_BIT = 3;
  localparam int ST_TO_BIT = 4;
  localparam int ST_SLEEP_BIT = 5;

  // Watchdog word field positions and wake bit.
  localparam int WDOG_CNT_LSB = 0;
  localparam int WDOG_PRE_LSB = 8;
  localparam int WAKE_BIT = 0;

  // Reset values and file geometry.
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic PD_RST = 1'b1;
  localparam logic TO_RST = 1'b1;
  localparam int FILE_DEPTH = 128;
  localparam int FADDR_W = 7;
  localparam int PRE_W_DEF = 8;

  // Operation codes carried in the instruction word.
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ROTATE_RIGHT_CARRY = 3'h1,
    OP_LITERAL_MINUS_ACC = 3'h2,
    OP_REG_MINUS_ACC = 3'h3,
    OP_REG_MINUS_ACC_BORROW = 3'h4,
    OP_SLEEP = 3'h5
  } op_e;

  // Execution state of the core.
  typedef enum logic [1:0] {
    RUN_MODE = 2'b01,
    SLEEP_MODE = 2'b10
  } run_e;

  // Merges a written word into an old one under the byte strobes.
  function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [3:0] strb);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_strb

endpackage : exec_pkg

// [rtl/alu_if.sv]
// Purpose: Carries operands and results between the core control and the arithmetic unit.
// Assumes: The control side drives operands, the unit answers combinationally.
// Notes: One operation per cycle.
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
  import exec_pkg::*;
  op_e op;
  logic [7:0] acc;
  logic [7:0] fval;
  logic [7:0] lit;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  logic half_carry_out;
  logic zero_out;
  logic carry_we;
  logic arith_we;
  modport core (output op, acc, fval, lit, carry_in,
                input result, carry_out, half_carry_out, zero_out, carry_we, arith_we);
  modport unit (input op, acc, fval, lit, carry_in,
                output result, carry_out, half_carry_out, zero_out, carry_we, arith_we);
endinterface : alu_if
`default_nettype wire

// [rtl/sub_rot_alu.sv]
// Purpose: Combinational rotate and subtract unit with flag results.
// Assumes: Operands are stable for the cycle in which the result is used.
// Notes: Subtraction adds the inverted accumulator plus a carry-in.
`timescale 1ns/1ps
`default_nettype none
module sub_rot_alu (
  alu_if.unit bus
);
  import exec_pkg::*;

  logic [7:0] minuend;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] nib5;

  // Picks the minuend and carry-in, then forms the full and nibble sums.
  always_comb begin
    minuend = (bus.op == OP_LITERAL_MINUS_ACC) ? bus.lit : bus.fval;
    cin = (bus.op == OP_REG_MINUS_ACC_BORROW) ? bus.carry_in : 1'b1; // see RULE6
    sum9 = {1'b0, minuend} + {1'b0, ~bus.acc} + {8'h00, cin};
    nib5 = {1'b0, minuend[3:0]} + {1'b0, ~bus.acc[3:0]} + {4'h0, cin};
  end

  // Selects the result and which flags the operation touches.
  always_comb begin
    bus.result = 8'h00;
    bus.carry_out = bus.carry_in;
    bus.half_carry_out = nib5[4];
    bus.zero_out = (sum9[7:0] == 8'h00); // see RULE10
    bus.carry_we = 1'b0;
    bus.arith_we = 1'b0;
    unique case (bus.op)
      OP_ROTATE_RIGHT_CARRY: begin
        bus.result = {bus.carry_in, bus.fval[7:1]}; // see RULE1
        bus.carry_out = bus.fval[0];
        bus.carry_we = 1'b1;
      end
      OP_LITERAL_MINUS_ACC, OP_REG_MINUS_ACC, OP_REG_MINUS_ACC_BORROW: begin
        bus.result = sum9[7:0]; // see RULE3 see RULE4
        bus.carry_out = sum9[8];
        bus.carry_we = 1'b1;
        bus.arith_we = 1'b1;
      end
      default: begin
        bus.result = 8'h00;
      end
    endcase
  end

endmodule : sub_rot_alu
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the rotate, subtract and sleep execution slice.
// Assumes: Bus tasks enter and leave just after a rising edge of clk_i.
// Notes: The watchdog never wraps here, so the timeout flag stays set until sleep.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import exec_pkg::*;

  localparam logic [6:0] FADDR = 7'h7f;
  localparam int MAX_CYCLES = 20000;

  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [ADDR_W-1:0] awaddr_i = '0;
  logic awvalid_i = 1'b0;
  logic awready_o;
  logic [DATA_W-1:0] wdata_i = '0;
  logic [3:0] wstrb_i = 4'hf;
  logic wvalid_i = 1'b0;
  logic wready_o;
  logic [1:0] bresp_o;
  logic bvalid_o;
  logic bready_i = 1'b0;
  logic [ADDR_W-1:0] araddr_i = '0;
  logic arvalid_i = 1'b0;
  logic arready_o;
  logic [DATA_W-1:0] rdata_o;
  logic [1:0] rresp_o;
  logic rvalid_o;
  logic rready_i = 1'b0;
  logic sleeping_o;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [1:0] resp;
  logic [31:0] rd;

  // Device under test with the default prescaler width.
  exec_slice #(.PRE_W(8)) DUT (
    .clk_i(clk_i), .nrst_i(nrst_i),
    .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
    .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
    .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
    .sleeping_o(sleeping_o)
  );

  // Free-running 50 MHz clock.
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // Cuts a hung run short.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == MAX_CYCLES) begin
      bad_count = bad_count + 1;
      $display("Error at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  // Compares one 32-bit result.
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check32

  // One AXI4-Lite write; address and data offered together, each dropped when taken.
  task automatic axi_wr(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] br);
    logic aw_ok;
    logic w_ok;
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr_i <= addr;
    wdata_i <= data;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge clk_i);
      aw_ok = awvalid_i && awready_o;
      w_ok = wvalid_i && wready_o;
      @(posedge clk_i);
      if (aw_ok) begin
        awvalid_i <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_ok) begin
        wvalid_i <= 1'b0;
        w_done = 1'b1;
      end
    end
    // Raised only after both channels are taken, so back-to-back writes never drive it twice.
    bready_i <= 1'b1;
    do begin
      @(negedge clk_i);
      aw_ok = bvalid_o;
      br = bresp_o;
      @(posedge clk_i);
    end while (aw_ok !== 1'b1);
    bready_i <= 1'b0;
  endtask : axi_wr

  // One AXI4-Lite read; returns data and response.
  task automatic axi_rd(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] rr);
    logic ok;
    araddr_i <= addr;
    arvalid_i <= 1'b1;
    do begin
      @(negedge clk_i);
      ok = arready_o;
      @(posedge clk_i);
    end while (ok !== 1'b1);
    arvalid_i <= 1'b0;
    rready_i <= 1'b1;
    do begin
      @(negedge clk_i);
      ok = rvalid_o;
      data = rdata_o;
      rr = rresp_o;
      @(posedge clk_i);
    end while (ok !== 1'b1);
    rready_i <= 1'b0;
  endtask : axi_rd

  // Runs one instruction on fresh operands and checks acc, file register and flags.
  task automatic run_op(input op_e op, input logic dest, input logic [7:0] acc,
                        input logic [7:0] opnd, input logic cin, input logic [1:0] pre);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] res;
    logic c;
    logic dc;
    logic z;
    logic bin;
    logic to_file;
    axi_wr(OFS_ACC, {24'h0, acc}, resp);
    axi_wr(OFS_FDATA, {24'h0, opnd}, resp);
    axi_wr(OFS_STATUS, {29'h0, pre, cin}, resp);
    axi_wr(OFS_INSTR, {8'h0, opnd, 1'b0, FADDR, dest, 4'h0, op}, resp);
    if (op == OP_ROTATE_RIGHT_CARRY) begin
      res = {cin, opnd[7:1]};
      c = opnd[0];
      {z, dc} = pre;
    end else begin
      bin = (op == OP_REG_MINUS_ACC_BORROW) ? ~cin : 1'b0;
      d = {1'b0, opnd} - {1'b0, acc} - {8'h0, bin};
      h = {1'b0, opnd[3:0]} - {1'b0, acc[3:0]} - {4'h0, bin};
      res = d[7:0];
      c = ~d[8];
      dc = ~h[4];
      z = (res == 8'h00);
    end
    to_file = dest && (op != OP_LITERAL_MINUS_ACC);
    axi_rd(OFS_ACC, rd, resp);
    check32(rd, {24'h0, to_file ? acc : res});
    axi_rd(OFS_FDATA, rd, resp);
    check32(rd, {24'h0, to_file ? res : opnd});
    axi_rd(OFS_STATUS, rd, resp);
    check32(rd, {27'h0, 1'b1, 1'b1, z, dc, c});
  endtask : run_op

  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    axi_rd(OFS_STATUS, rd, resp);
    check32(rd, 32'h18);
    axi_rd(OFS_ACC, rd, resp);
    check32(rd, 32'h0);
    // Unmapped offset is refused on both paths.
    axi_wr(8'h1c, 32'h5a, resp);
    check32({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_rd(8'h1c, rd, resp);
    check32({30'h0, resp}, {30'h0, RESP_SLVERR});
    check32(rd, 32'h0);
    axi_wr(OFS_FSEL, {25'h0, FADDR}, resp);
    run_op(OP_ROTATE_RIGHT_CARRY, 1'b1, 8'h00, 8'h81, 1'b1, 2'b11);
    run_op(OP_ROTATE_RIGHT_CARRY, 1'b0, 8'h55, 8'h02, 1'b0, 2'b10);
    run_op(OP_LITERAL_MINUS_ACC, 1'b0, 8'h05, 8'h05, 1'b0, 2'b00);
    run_op(OP_LITERAL_MINUS_ACC, 1'b0, 8'h06, 8'h05, 1'b1, 2'b00);
    run_op(OP_LITERAL_MINUS_ACC, 1'b0, 8'h10, 8'h0f, 1'b0, 2'b00);
    run_op(OP_LITERAL_MINUS_ACC, 1'b1, 8'h1f, 8'h20, 1'b0, 2'b00);
    run_op(OP_REG_MINUS_ACC, 1'b0, 8'h05, 8'h05, 1'b0, 2'b00);
    run_op(OP_REG_MINUS_ACC, 1'b0, 8'h30, 8'h21, 1'b1, 2'b00);
    run_op(OP_REG_MINUS_ACC, 1'b1, 8'h01, 8'h00, 1'b1, 2'b00);
    run_op(OP_REG_MINUS_ACC_BORROW, 1'b0, 8'h05, 8'h06, 1'b0, 2'b00);
    run_op(OP_REG_MINUS_ACC_BORROW, 1'b0, 8'h10, 8'h10, 1'b1, 2'b00);
    run_op(OP_REG_MINUS_ACC_BORROW, 1'b1, 8'h00, 8'h00, 1'b0, 2'b00);
    run_op(OP_REG_MINUS_ACC_BORROW, 1'b1, 8'h0f, 8'h1e, 1'b1, 2'b00);
    // Sleep: flags, watchdog and halt.
    axi_wr(OFS_ACC, 32'h3c, resp);
    repeat (20) @(posedge clk_i);
    axi_wr(OFS_INSTR, {29'h0, OP_SLEEP}, resp);
    axi_rd(OFS_WDOG, rd, resp);
    check32(rd, 32'h0);
    axi_rd(OFS_STATUS, rd, resp);
    check32(rd & 32'h38, 32'h30);
    check32({31'h0, sleeping_o}, 32'h1);
    axi_wr(OFS_INSTR, {8'h0, 8'h77, 8'h00, 5'h0, OP_LITERAL_MINUS_ACC}, resp);
    repeat (50) @(posedge clk_i);
    axi_rd(OFS_ACC, rd, resp);
    check32(rd, 32'h3c);
    axi_rd(OFS_WDOG, rd, resp);
    check32(rd, 32'h0);
    axi_wr(OFS_WAKE, 32'h1, resp);
    check32({31'h0, sleeping_o}, 32'h0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
